// ===== bench/pfm_mux_tb.sv
/* bench for pfm_mux: AXI4-Lite master, pad model, queue scoreboard.
   assumes pfm_pkg, the pad model and the checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module pfm_mux_tb;
  localparam logic [1:0] OK = pfm_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pfm_pkg::RESP_SLVERR;
  logic aclk = 1'h0, aresetn = 1'h0, look = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, view, r = 32'h1A464385;
  logic [2:0] sel = 3'h0;
  logic [3:0] v6, v7;
  logic [33:0] q[$];
  int n_errors = 0, total_checks = 0;
  pfm_pkg::pfm_periph_t periph = '0;
  pfm_pkg::pfm_async_t async_in = '0;
  pfm_pkg::pfm_analog_t analog_sw;
  pfm_pkg::pfm_route_t route;
  pfm_pkg::pfm_pads_t pad_in, pad_out, pad_oe, ext = '0;
  pfm_pkg::pfm_pads_t ext_en = 23'h7FF87F; // port 2 left to pull-ups
  logic [3:0] p2_pullup;
  always #25 aclk = ~aclk;
  pfm_mux pfm_mux_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph(periph),
    .async_in(async_in), .analog_sw(analog_sw), .route(route),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .p2_pullup(p2_pullup));
  pfm_pad_model pfm_pad_model_inst (.aclk(aclk), .pad_out(pad_out),
    .pad_oe(pad_oe), .p2_pullup(p2_pullup), .ext(ext), .ext_en(ext_en),
    .pad_in(pad_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // output group under comparison
  always_comb begin
    case (sel)
      3'h1: view = {23'h0, p2_pullup, pad_oe.p2, pad_out.p2[3]};
      3'h2: view = {28'h0, pad_oe.p3[7:6], pad_out.p3[7:6]};
      3'h3: view = {25'h0, pad_oe.p4, pad_out.p4[3:2], pad_out.p4[0]};
      3'h4: view = {22'h0, analog_sw};
      default: view = {24'h0, route[8:1]};
    endcase
  end
  // each answer or look takes the oldest note off the queue
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready) || look) begin
      total_checks++;
      if (q.size() == 0 || q[0] !== (look ? {2'h0, view} :
          bvalid ? {bresp, 32'h0} : {rresp, rdata})) begin
        n_errors++;
        $display("[FAIL] %0t result differs from note", $time);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [1:0] e);
    logic [2:0] f;
    q.push_back({e, w ? 32'h0 : d});
    if (w) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    else {araddr, arvalid, rready} <= {a, 2'h3};
    // sample at the falling edge, act just after the rising one
    do begin
      @(negedge aclk);
      f = w ? {awvalid && awready, wvalid && wready, bvalid} :
        {arvalid && arready, 1'h0, rvalid};
      @(posedge aclk);
      if (f[2]) {awvalid, arvalid} <= 2'h0;
      if (f[1]) wvalid <= 1'h0;
    end while (!f[0]);
    {bready, rready} <= 2'h0;
    repeat (4) @(posedge aclk); // pads 1 edge, synced inputs 3 edges
  endtask
  task automatic see(input logic [2:0] s, input logic [31:0] e);
    q.push_back({2'h0, e});
    {sel, look} <= {s, 1'h1};
    @(posedge aclk);
    look <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog; the run needs about 310 cycles
  initial begin
    #1000000;
    n_errors++;
    conclude();
  end
  initial begin
    int c, s;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    r = lfsr(r);
    periph <= r[9:0];
    async_in <= r[29:16] | 14'h1; // pump ok high, pump clock ungated
    r = lfsr(r);
    ext <= r[22:0];
    @(posedge aclk);
    xfer(1'h0, 12'h014, pfm_pkg::RSTVAL[5], OK);
    see(3'h1, {23'h0, 4'h7, 4'h8, periph.jtag_tdo});
    xfer(1'h0, 12'h01C, 32'h0, ERR);
    xfer(1'h1, 12'h040, r, ERR);
    $display("reset test done");
    xfer(1'h1, 12'h014, 32'h00001000, OK);
    xfer(1'h1, 12'h004, {16'h0, r[3:0], 12'h00F}, OK);
    see(3'h1, {23'h0, 4'h0, 4'hF, r[3]});
    see(3'h0, {24'h0, 1'h0, ext.p3[5], ext.p3[6], ext.p3[7], 4'hE});
    xfer(1'h1, 12'h004, 32'h0000088F, OK);
    see(3'h1, {23'h0, 4'h7, 4'h8, periph.jtag_tdo});
    $display("jtag test done");
    for (c = 1; c < 4; c++) begin
      for (s = 0; s < 4; s++) begin
        xfer(1'h1, 12'h008, {8'h0, {2{c[1]}}, 6'h0, {2{c[0]}}, 14'h00C0}, OK);
        xfer(1'h1, 12'h014, {26'h0, s[1:0], 2'h0, s[1:0]}, OK);
        v6 = {periph.t1_out[1], periph.t0_out} ^ {4{c[1]}};
        v7 = {async_in.lcd_comp, periph.t0_out} ^ {4{c[1]}};
        if (c == 3) v6 = {async_in.battery_boost_pump_ok,
          async_in.low_freq_clock, async_in.activation_sense,
          async_in.brownout_indicator};
        if (c == 3) v7 = {async_in.act_osc_1khz, async_in.high_freq_clock,
          async_in.lcd_frame_clock, async_in.lcd_pump_clock};
        see(3'h2, {28'h0, 2'h3, v7[s], v6[s]});
      end
    end
    $display("port 3 test done");
    xfer(1'h1, 12'h000, 32'h00000001, OK);
    xfer(1'h1, 12'h010, 32'h00001212, OK);
    see(3'h4, 32'h043);
    xfer(1'h1, 12'h010, 32'h00000202, OK);
    xfer(1'h0, 12'h010, 32'h00000202, OK);
    see(3'h4, 32'h022);
    $display("analog test done");
    xfer(1'h1, 12'h008, 32'h0, OK);
    xfer(1'h1, 12'h014, 32'h00020000, OK);
    xfer(1'h1, 12'h00C, 32'h00000880, OK);
    see(3'h3, {25'h0, 4'hD, async_in.act_osc_1khz, periph.spi_sclk,
      periph.spi_cs});
    see(3'h0, {24'h0, ext.p3[4], ext.p3[5], ext.p3[6], ext.p3[7], 3'h7,
      ext.p4[1]});
    $display("spi boot test done");
    conclude();
  end
endmodule
`default_nettype wire

// ===== bench/pfm_pad_model.sv
/* pad model for pfm_mux: the level each pad shows from all its drivers.
   assumes the bench gives what outside circuits drive, with enables. */
`timescale 1ns/100ps
`default_nettype none
module pfm_pad_model (
  input wire logic aclk,
  input wire pfm_pkg::pfm_pads_t pad_out,
  input wire pfm_pkg::pfm_pads_t pad_oe,
  input wire logic [3:0] p2_pullup,
  input wire pfm_pkg::pfm_pads_t ext,
  input wire pfm_pkg::pfm_pads_t ext_en,
  output var pfm_pkg::pfm_pads_t pad_in
);
  pfm_pkg::pfm_pads_t float_r = '0;
  // a floating pad flips each cycle so a stale level never reads back
  always @(posedge aclk) float_r <= ~float_r;
  // design drive wins, then outside circuit, then pull-up or float
  always_comb begin
    pad_in = float_r;
    pad_in.p2 = float_r.p2 | p2_pullup;
    pad_in = (pad_in & ~ext_en) | (ext & ext_en);
    pad_in = (pad_in & ~pad_oe) | (pad_out & pad_oe);
  end
endmodule
`default_nettype wire

// ===== bench/pfm_sva.sv
/* checker for pfm_mux: assertions on pads, switches and routes.
   assumes one aclk domain; attached by the bind at the foot. */
`timescale 1ns/100ps
`default_nettype none
module pfm_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pfm_pkg::pfm_periph_t periph,
  input wire pfm_pkg::pfm_analog_t analog_sw,
  input wire pfm_pkg::pfm_route_t route,
  input wire pfm_pkg::pfm_pads_t pad_in,
  input wire pfm_pkg::pfm_pads_t pad_oe,
  input wire pfm_pkg::pfm_pads_t pad_out,
  input wire logic [3:0] p2_pullup
);
  logic [2:0] up_r;
  // edges since reset; the input sync needs three before routes hold
  always_ff @(posedge aclk) begin
    if (!aresetn) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_jtag_oe: assert property (up_r[2] && p2_pullup == 4'h7 |->
    pad_oe.p2 == 4'h8) else $error("jtag pad drive wrong");
  a_tdo_out: assert property (up_r[2] && p2_pullup == 4'h7 |->
    pad_out.p2[3] == $past(periph.jtag_tdo)) else $error("tdo wrong");
  a_jtag_ones: assert property (p2_pullup == 4'h0 &&
    $past(p2_pullup, 3) == 4'h0 |-> route.jtag_tck && route.jtag_tms &&
    route.jtag_tdi) else $error("jtag inputs not high");
  a_cap_one: assert property (up_r[2] |->
    route.capture_input_one_a3 == $past(pad_in.p3[6], 3))
    else $error("capture one a3 wrong");
  a_cap_a1: assert property (up_r[2] |->
    route.capture_input_two_a1 == $past(pad_in.p3[7], 3))
    else $error("capture two a1 wrong");
  a_cap_a2: assert property (up_r[2] && route.capture_input_two_a2 |->
    $past(pad_in.p3[4], 3)) else $error("capture two a2 wrong");
  a_reg_first: assert property (analog_sw.regulator_connect[0] |->
    !analog_sw.a2_connect && !pad_oe.p1[0]) else $error("regulator clash");
  a_ref_wins: assert property (analog_sw.ref_connect |->
    !analog_sw.a3b_connect) else $error("reference and a3b both on");
endmodule
bind pfm_mux pfm_sva pfm_sva_inst (.aclk(aclk), .aresetn(aresetn),
  .periph(periph), .analog_sw(analog_sw), .route(route), .pad_in(pad_in),
  .pad_oe(pad_oe), .pad_out(pad_out), .p2_pullup(p2_pullup));
`default_nettype wire

// ===== hw/pfm_mux.sv
/*
  Pad function mux with AXI4-Lite control registers.
  Assumes pads and foreign clocks are asynchronous to aclk.
*/
`timescale 1ns/100ps
`default_nettype none

// Contract
// (RL1) code 00 is GPIO, others pick outputs; drive only on dir=1
// (RL2) regulator enable and dir=1 put 1 V on that pad
// (RL3) channel 2 connects port1 pad0 to analog input A2
// (RL4) port1 pad3: A3b on channel 2; reference out wins
// (RL5) TMS, TCK, TDI read 1 outside JTAG mode
// (RL6) JTAG mode overrides port 2 direction, select and output
// (RL7) after reset TCK, TMS, TDI are JTAG, pull-ups on
// (RL8) after reset TDO is JTAG, pull-up off
// (RL9) port2 pad3 dir=1 code 11 is TDO, port 2 goes JTAG
// (RL10) port3 pad4 feeds capture two A2 while its buffer is on
// (RL11) port3 pad5 feeds capture two A3 while its buffer is on
// (RL12) port3 pad6 always feeds capture one A3
// (RL13) port3 pad7 feeds capture two A1
// (RL14) port3 pad6 sub-select: timers, inverted timers, status
// (RL15) port3 pad7 code 11: pump, frame, fast and 1 kHz clocks
// (RL16) port3 pad7 sub 11: comparator on 01, inverted on 10
// (RL17) nonzero test select routes analog test out to port4 pad0
// (RL18) port4 pad3 code 11 drives 1 kHz oscillator
// (RL19) SPI boot, code 00: port4 carries cs, din, clk, dout
// (RL20) pump ok gates LCD pump clock and power-ok output

module pfm_mux (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [pfm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pfm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripherals and analog
  input wire pfm_pkg::pfm_periph_t periph,
  input wire pfm_pkg::pfm_async_t async_in,
  output pfm_pkg::pfm_analog_t analog_sw,
  output pfm_pkg::pfm_route_t route,
  // pads
  input wire pfm_pkg::pfm_pads_t pad_in,
  output pfm_pkg::pfm_pads_t pad_out,
  output pfm_pkg::pfm_pads_t pad_oe,
  output logic [3:0] p2_pullup
);

  // ---------------------------------------------------------------------
  // register storage and bus slave
  // ---------------------------------------------------------------------
  logic [31:0] ctrl_r [0:pfm_pkg::NREG-2];
  logic [31:0] status_w;
  logic aw_got_r;
  logic w_got_r;
  logic [pfm_pkg::ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic [2:0] wr_idx;
  logic wr_bad;
  logic [2:0] rd_idx;
  logic rd_bad;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_idx = awaddr_r[4:2];
  // the status word accepts writes silently; beyond it is unmapped
  assign wr_bad = (awaddr_r[pfm_pkg::ADDR_W-1:5] != '0) ||
                  (wr_idx > pfm_pkg::IDX_STAT);
  assign rd_idx = s_axi_araddr[4:2];
  assign rd_bad = (s_axi_araddr[pfm_pkg::ADDR_W-1:5] != '0) ||
                  (rd_idx > pfm_pkg::IDX_STAT);

  // address and data are taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pfm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_bad ? pfm_pkg::RESP_SLVERR : pfm_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control registers, byte strobes and writable masks per word
  genvar gr;
  generate
    for (gr = 0; gr < pfm_pkg::NREG - 1; gr++) begin : g_reg
      logic [31:0] lane_m;
      assign lane_m = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                       {8{wstrb_r[1]}}, {8{wstrb_r[0]}}} &
                      pfm_pkg::WMASK[gr];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctrl_r[gr] <= pfm_pkg::RSTVAL[gr]; // RL7 RL8
        end else if (wr_fire && !wr_bad && wr_idx == 3'(gr)) begin
          ctrl_r[gr] <= (ctrl_r[gr] & ~lane_m) | (wdata_r & lane_m);
        end
      end
    end
  endgenerate

  // read channel; data held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pfm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rd_bad ? pfm_pkg::RESP_SLVERR : pfm_pkg::RESP_OKAY;
      if (rd_bad) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (rd_idx == pfm_pkg::IDX_STAT) begin
        s_axi_rdata <= status_w;
      end else begin
        s_axi_rdata <= ctrl_r[rd_idx];
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------------
  logic [6:0] dir1, lo1, hi1, out1;
  logic [3:0] dir2, lo2, hi2, out2, dir4, lo4, hi4, out4;
  logic [7:0] dir3, lo3, hi3, out3, in_buf_off;
  logic [3:0] analog_channel_select, regulator_pad_enable, ana_test_sel;
  logic analog_out_enable, reference_out_enable, a3_source_select;
  logic [1:0] pad36_sub_select, pad37_sub_select;
  logic jtag_mode_bit, spi_boot;

  logic [31:0] c1, c2, c3, c4, ca, cm;
  assign c1 = ctrl_r[pfm_pkg::IDX_P1];
  assign c2 = ctrl_r[pfm_pkg::IDX_P2];
  assign c3 = ctrl_r[pfm_pkg::IDX_P3];
  assign c4 = ctrl_r[pfm_pkg::IDX_P4];
  assign ca = ctrl_r[pfm_pkg::IDX_ANA];
  assign cm = ctrl_r[pfm_pkg::IDX_MISC];
  assign dir1 = c1[pfm_pkg::W_DIR +: 7];
  assign lo1 = c1[pfm_pkg::W_LO +: 7];
  assign hi1 = c1[pfm_pkg::W_HI +: 7];
  assign out1 = c1[pfm_pkg::W_OUT +: 7];
  assign dir2 = c2[pfm_pkg::N_DIR +: 4];
  assign lo2 = c2[pfm_pkg::N_LO +: 4];
  assign hi2 = c2[pfm_pkg::N_HI +: 4];
  assign out2 = c2[pfm_pkg::N_OUT +: 4];
  assign dir3 = c3[pfm_pkg::W_DIR +: 8];
  assign lo3 = c3[pfm_pkg::W_LO +: 8];
  assign hi3 = c3[pfm_pkg::W_HI +: 8];
  assign out3 = c3[pfm_pkg::W_OUT +: 8];
  assign dir4 = c4[pfm_pkg::N_DIR +: 4];
  assign lo4 = c4[pfm_pkg::N_LO +: 4];
  assign hi4 = c4[pfm_pkg::N_HI +: 4];
  assign out4 = c4[pfm_pkg::N_OUT +: 4];
  assign analog_channel_select = ca[pfm_pkg::A_CHAN +: 4];
  assign regulator_pad_enable = ca[pfm_pkg::A_REGEN +: 4];
  assign analog_out_enable = ca[pfm_pkg::A_OUTEN];
  assign reference_out_enable = ca[pfm_pkg::A_REFEN];
  assign a3_source_select = ca[pfm_pkg::A_A3SEL];
  assign ana_test_sel = ca[pfm_pkg::A_ATEST +: 4];
  assign pad36_sub_select = cm[pfm_pkg::M_SUB36 +: 2];
  assign pad37_sub_select = cm[pfm_pkg::M_SUB37 +: 2];
  assign in_buf_off = cm[pfm_pkg::M_IBOFF +: 8];
  assign jtag_mode_bit = cm[pfm_pkg::M_JTAG];
  assign spi_boot = cm[pfm_pkg::M_SPI];

  // ---------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------
  pfm_pkg::pfm_pads_t pad_meta_r, pad_sync_r;
  pfm_pkg::pfm_async_t asy_meta_r, a;

  // pads and foreign signals cross in two stages before any use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_meta_r <= '0;
      pad_sync_r <= '0;
      asy_meta_r <= '0;
      a <= '0;
    end else begin
      pad_meta_r <= pad_in;
      pad_sync_r <= pad_meta_r;
      asy_meta_r <= async_in;
      a <= asy_meta_r;
    end
  end

  logic jtag_active;
  logic pump_ok;
  assign pump_ok = a.battery_boost_pump_ok;
  // TDO configuration alone switches the whole port into JTAG
  assign jtag_active = jtag_mode_bit ||
                       (dir2[3] && hi2[3] && lo2[3]); // RL9

  assign status_w = {2'b00, jtag_active, pump_ok, pad_sync_r.p4,
                     pad_sync_r.p3, 4'h0, pad_sync_r.p2, 1'b0,
                     pad_sync_r.p1};

  // ---------------------------------------------------------------------
  // pad function selection
  // ---------------------------------------------------------------------
  // one ordinary pad: 00 is GPIO, otherwise the alternate, driven on dir
  function automatic logic [1:0] pick(input logic dir,
                                      input logic [1:0] s,
                                      input logic gpio,
                                      input logic [3:1] alt);
    logic o;
    o = (s == 2'b00) ? gpio : alt[s];
    return {dir, o}; // RL1
  endfunction

  logic [3:0] tsel;
  logic [3:1] alt1 [0:6];
  logic [3:1] alt2 [0:3];
  logic [3:1] alt3 [0:7];
  logic [3:1] alt4 [0:3];
  pfm_pkg::pfm_pads_t out_nxt, oe_nxt;
  pfm_pkg::pfm_analog_t ana_nxt;
  logic [3:0] pull_nxt;
  logic t36, t37;
  logic [3:0] spi_v;

  // alternate function tables per pad
  always_comb begin
    tsel = {periph.t1_out[1], periph.t0_out};
    t36 = tsel[pad36_sub_select];
    t37 = (pad37_sub_select == 2'b11) ? a.lcd_comp :
          periph.t0_out[pad37_sub_select];
    for (int i = 0; i < 7; i++) begin
      alt1[i] = {periph.t0_out[1], periph.t1_out[2], periph.t0_out[2]};
    end
    alt1[3] = {periph.t0_out[2], periph.t1_out[1], periph.t0_out[2]};
    alt1[6] = {periph.t1_out[1], periph.t1_out[2], periph.t0_out[2]};
    alt2[0] = {a.comparator_result, periph.t1_out[2], periph.t1_out[1]};
    alt2[1] = {periph.t0_out[2], periph.t0_out[1], a.ext_clock};
    alt2[2] = {a.comparator_result, periph.t1_out[0], a.high_freq_clock};
    alt2[3] = {periph.jtag_tdo, periph.t0_out[2], a.low_freq_clock};
    for (int i = 0; i < 6; i++) begin
      alt3[i] = {periph.t1_out[0], periph.t1_out[1], periph.t0_out[1]};
    end
    case (pad36_sub_select) // RL14
      2'b00: alt3[6][3] = a.brownout_indicator;
      2'b01: alt3[6][3] = a.activation_sense;
      2'b10: alt3[6][3] = a.low_freq_clock;
      default: alt3[6][3] = pump_ok;
    endcase
    alt3[6][2:1] = {~t36, t36}; // RL14
    case (pad37_sub_select) // RL15
      2'b00: alt3[7][3] = a.lcd_pump_clock && pump_ok; // RL20
      2'b01: alt3[7][3] = a.lcd_frame_clock;
      2'b10: alt3[7][3] = a.high_freq_clock;
      default: alt3[7][3] = a.act_osc_1khz;
    endcase
    alt3[7][2:1] = {~t37, t37}; // RL16
    alt4[0] = {a.aux_clock, periph.t1_out[2], periph.t0_out[2]};
    alt4[1] = {a.subsystem_clock, periph.t1_out[2], periph.t0_out[2]};
    alt4[2] = {a.main_clock, periph.t1_out[2], periph.t0_out[2]};
    alt4[3] = {a.act_osc_1khz, periph.t1_out[2], periph.t0_out[2]};
  end

  // pad drive with overrides, later assignments take priority
  always_comb begin
    out_nxt = '0;
    oe_nxt = '0;
    ana_nxt = '0;
    pull_nxt = 4'h0;
    spi_v = {periph.spi_dout, periph.spi_sclk, 1'b0, periph.spi_cs};
    for (int i = 0; i < 7; i++) begin
      {oe_nxt.p1[i], out_nxt.p1[i]} =
        pick(dir1[i], {hi1[i], lo1[i]}, out1[i], alt1[i]);
    end
    for (int i = 0; i < 4; i++) begin
      {oe_nxt.p2[i], out_nxt.p2[i]} =
        pick(dir2[i], {hi2[i], lo2[i]}, out2[i], alt2[i]);
      {oe_nxt.p4[i], out_nxt.p4[i]} =
        pick(dir4[i], {hi4[i], lo4[i]}, out4[i], alt4[i]);
    end
    for (int i = 0; i < 8; i++) begin
      {oe_nxt.p3[i], out_nxt.p3[i]} =
        pick(dir3[i], {hi3[i], lo3[i]}, out3[i], alt3[i]);
    end
    // on-chip clock to port4 pads 1 to 3 needs no direction
    for (int i = 1; i < 4; i++) begin
      if (hi4[i] && lo4[i]) begin
        oe_nxt.p4[i] = 1'b1; // RL18
      end
    end
    // bootstrap loader owns port 4 pads whose selects are 00; pad 1 is din
    for (int i = 0; i < 4; i++) begin
      if (spi_boot && !hi4[i] && !lo4[i]) begin
        oe_nxt.p4[i] = (i != 1); // RL19
        out_nxt.p4[i] = spi_v[i]; // RL19
      end
    end
    if (ana_test_sel != 4'h0) begin
      ana_nxt.atest_connect = 1'b1; // RL17
      oe_nxt.p4[0] = 1'b0; // RL17
    end
    // analog switches release the digital driver
    if (analog_channel_select == pfm_pkg::CHAN_A2) begin
      ana_nxt.a2_connect = 1'b1; // RL3
      oe_nxt.p1[0] = 1'b0; // RL3
    end
    if (analog_out_enable && !a3_source_select && dir1[2]) begin
      ana_nxt.aout_connect = 1'b1;
      oe_nxt.p1[2] = 1'b0;
    end else if (analog_channel_select == pfm_pkg::CHAN_A3A &&
                 !analog_out_enable && !a3_source_select) begin
      ana_nxt.a3a_connect = 1'b1;
      oe_nxt.p1[2] = 1'b0;
    end
    if (reference_out_enable) begin
      ana_nxt.ref_connect = 1'b1; // RL4
      oe_nxt.p1[3] = 1'b0; // RL4
    end else if (analog_channel_select == pfm_pkg::CHAN_A2 &&
                 !a3_source_select) begin
      ana_nxt.a3b_connect = 1'b1; // RL4
      oe_nxt.p1[3] = 1'b0; // RL4
    end
    // regulator beats every other setting of its pads
    ana_nxt.regulator_connect =
      regulator_pad_enable & {dir3[3], dir1[4], dir1[1], dir1[0]}; // RL2
    ana_nxt.a2_connect = ana_nxt.a2_connect &&
      !ana_nxt.regulator_connect[0]; // RL2
    {oe_nxt.p3[3], oe_nxt.p1[4], oe_nxt.p1[1], oe_nxt.p1[0]} =
      {oe_nxt.p3[3], oe_nxt.p1[4], oe_nxt.p1[1], oe_nxt.p1[0]} &
      ~ana_nxt.regulator_connect; // RL2
    // JTAG owns port 2: inputs on pads 0 to 2, TDO out on pad 3
    if (jtag_active) begin
      oe_nxt.p2 = 4'b1000; // RL6
      out_nxt.p2 = {periph.jtag_tdo, 3'b000}; // RL6
      pull_nxt = 4'b0111; // RL7 RL8
    end
  end

  // ---------------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------------
  pfm_pkg::pfm_route_t route_nxt;

  // input routing; the JTAG inputs idle high outside JTAG mode
  always_comb begin
    route_nxt.capture_input_two_a2 =
      pad_sync_r.p3[4] && !in_buf_off[4]; // RL10
    route_nxt.capture_input_two_a3 =
      pad_sync_r.p3[5] && !in_buf_off[5]; // RL11
    route_nxt.capture_input_one_a3 = pad_sync_r.p3[6]; // RL12
    route_nxt.capture_input_two_a1 = pad_sync_r.p3[7]; // RL13
    route_nxt.jtag_tck = jtag_active ? pad_sync_r.p2[0] : 1'b1; // RL5
    route_nxt.jtag_tms = jtag_active ? pad_sync_r.p2[1] : 1'b1; // RL5
    route_nxt.jtag_tdi = jtag_active ? pad_sync_r.p2[2] : 1'b1; // RL5
    route_nxt.spi_din = spi_boot && pad_sync_r.p4[1]; // RL19
    route_nxt.peripheral_power_ok = pump_ok; // RL20
  end

  // one flop stage keeps pad and switch changes glitch free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out <= '0;
      pad_oe <= '0;
      analog_sw <= '0;
      p2_pullup <= 4'b0111; // RL7 RL8
      route <= 9'h01C; // RL5
    end else begin
      pad_out <= out_nxt;
      pad_oe <= oe_nxt;
      analog_sw <= ana_nxt;
      p2_pullup <= pull_nxt;
      route <= route_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== inc/pfm_pkg.sv
/*
  Register map, field positions and carriers of the pad function mux.
  Assumes one aclk domain on the register side.
*/
`default_nettype none

package pfm_pkg;

  // ---------------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int NREG = 7;
  localparam logic [2:0] IDX_P1 = 3'h0;
  localparam logic [2:0] IDX_P2 = 3'h1;
  localparam logic [2:0] IDX_P3 = 3'h2;
  localparam logic [2:0] IDX_P4 = 3'h3;
  localparam logic [2:0] IDX_ANA = 3'h4;
  localparam logic [2:0] IDX_MISC = 3'h5;
  localparam logic [2:0] IDX_STAT = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // writable bits and reset value of each control register
  localparam logic [5:0][31:0] WMASK = {
    32'h0003_FF33, 32'h0000_F7FF, 32'h0000_FFFF,
    32'hFFFF_FFFF, 32'h0000_FFFF, 32'h7F7F_7F7F};
  localparam logic [5:0][31:0] RSTVAL = {
    32'h0001_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  // wide ports (p1, p3): dir, function lo, function hi, output value
  localparam int W_DIR = 0;
  localparam int W_LO = 8;
  localparam int W_HI = 16;
  localparam int W_OUT = 24;
  // narrow ports (p2, p4)
  localparam int N_DIR = 0;
  localparam int N_LO = 4;
  localparam int N_HI = 8;
  localparam int N_OUT = 12;
  // analog register
  localparam int A_CHAN = 0;
  localparam int A_REGEN = 4;
  localparam int A_OUTEN = 8;
  localparam int A_REFEN = 9;
  localparam int A_A3SEL = 10;
  localparam int A_ATEST = 12;
  // misc register
  localparam int M_SUB36 = 0;
  localparam int M_SUB37 = 4;
  localparam int M_IBOFF = 8;
  localparam int M_JTAG = 16;
  localparam int M_SPI = 17;
  // status register
  localparam int S_P1 = 0;
  localparam int S_P2 = 8;
  localparam int S_P3 = 16;
  localparam int S_P4 = 24;
  localparam int S_PUMP = 28;
  localparam int S_JTAG = 29;

  // analog channel codes that claim pads
  localparam logic [3:0] CHAN_A2 = 4'h2;
  localparam logic [3:0] CHAN_A3A = 4'h3;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] p4;
    logic [7:0] p3;
    logic [3:0] p2;
    logic [6:0] p1;
  } pfm_pads_t;

  // peripherals on the bus clock
  typedef struct packed {
    logic [2:0] t0_out;
    logic [2:0] t1_out;
    logic jtag_tdo;
    logic spi_cs;
    logic spi_sclk;
    logic spi_dout;
  } pfm_periph_t;

  // signals from other clocks or from analog circuits
  typedef struct packed {
    logic comparator_result;
    logic lcd_comp;
    logic low_freq_clock;
    logic high_freq_clock;
    logic subsystem_clock;
    logic aux_clock;
    logic main_clock;
    logic ext_clock;
    logic act_osc_1khz;
    logic lcd_pump_clock;
    logic lcd_frame_clock;
    logic brownout_indicator;
    logic activation_sense;
    logic battery_boost_pump_ok;
  } pfm_async_t;

  typedef struct packed {
    logic [3:0] regulator_connect;
    logic a2_connect;
    logic a3a_connect;
    logic aout_connect;
    logic a3b_connect;
    logic ref_connect;
    logic atest_connect;
  } pfm_analog_t;

  typedef struct packed {
    logic capture_input_two_a2;
    logic capture_input_two_a3;
    logic capture_input_one_a3;
    logic capture_input_two_a1;
    logic jtag_tck;
    logic jtag_tms;
    logic jtag_tdi;
    logic spi_din;
    logic peripheral_power_ok;
  } pfm_route_t;

endpackage

`default_nettype wire
